// File: verilog/roc_top.sv
// Purpose: APB register file and synchroniser around the relay core
// Assumes: 10 MHz pclk, signals from pins, zero wait state APB
// Notes: unmapped reads return zero with pslverr
//
// Register access over APB and the placing of the registers are this design's own decisions.
`timescale 1ns/1ns
`default_nettype none
module roc_top #(
  parameter int TICK_CYC = roc_pkg::ROC_TICK_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [roc_pkg::ROC_NUM_SRC-1:0] sig_in,
  output logic relay_drive
);
  import roc_pkg::*;
  // ==========================================
  // Input synchroniser
  logic [ROC_NUM_SRC-1:0] sync1_q;
  logic [ROC_NUM_SRC-1:0] sync2_q;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      sync1_q <= '0;
      sync2_q <= '0;
    end
    else
    begin
      sync1_q <= sig_in;
      sync2_q <= sync1_q;
    end
  end

  // ==========================================
  // Registers
  logic [31:0] ctrl_q;
  logic [31:0] sel_lo_q;
  logic [31:0] sel_hi_q;
  logic [14:0] hold_q;
  logic [14:0] off_q;
  roc_stat_s stat;
  logic tick;

  // Byte-lane merge
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] st);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++)
      if (st[b])
        r[b*8 +: 8] = wd[b*8 +: 8];
    return r;
  endfunction
  // Clamp time to 300.00 s
  function automatic logic [14:0] clamp(input logic [31:0] v);
    return (v[31:0] > 32'(ROC_TIME_MAX)) ? ROC_TIME_MAX : v[14:0];
  endfunction

  wire acc = psel && penable;
  wire wr = acc && pwrite;
  wire hit_ctrl = (paddr == ROC_OFS_CTRL);
  wire hit_sel_lo = (paddr == ROC_OFS_SEL_LO);
  wire hit_sel_hi = (paddr == ROC_OFS_SEL_HI);
  wire hit_hold = (paddr == ROC_OFS_HOLD);
  wire hit_off = (paddr == ROC_OFS_OFFDLY);
  wire hit_stat = (paddr == ROC_OFS_STAT);
  wire mapped = hit_ctrl | hit_sel_lo | hit_sel_hi | hit_hold | hit_off | hit_stat;
  wire [31:0] rd_mux = hit_ctrl ? ctrl_q :
                       hit_sel_lo ? sel_lo_q :
                       hit_sel_hi ? sel_hi_q :
                       hit_hold ? {17'h0, hold_q} :
                       hit_off ? {17'h0, off_q} :
                       hit_stat ? {27'h0, stat} : 32'h0;
  wire [31:0] hold_new = merge({17'h0, hold_q}, pwdata, pstrb);
  wire [31:0] off_new = merge({17'h0, off_q}, pwdata, pstrb);

  // Register writes; defaults keep inversion and latch off
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_q <= ROC_CTRL_RST;
      sel_lo_q <= ROC_SEL_RST;
      sel_hi_q <= ROC_SEL_RST;
      hold_q <= ROC_TIME_RST;
      off_q <= ROC_TIME_RST;
    end
    else if (wr)
    begin
      if (hit_ctrl)
        ctrl_q <= merge(ctrl_q, pwdata, pstrb) & 32'h1f03_7f7f;
      if (hit_sel_lo)
        sel_lo_q <= merge(sel_lo_q, pwdata, pstrb) & 32'h3fff_ffff;
      if (hit_sel_hi)
        sel_hi_q <= merge(sel_hi_q, pwdata, pstrb) & 32'h0000_001f;
      if (hit_hold)
        hold_q <= clamp(hold_new);
      if (hit_off)
        off_q <= clamp(off_new);
    end
  end

  // Bus answer, zero wait states
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= 32'h0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !mapped;
      prdata <= (psel && !penable && !pwrite) ? rd_mux : 32'h0;
    end
  end

  // ==========================================
  // Configuration view
  roc_cfg_s cfg;
  assign cfg.inv = ctrl_q[ROC_CTRL_INV_LSB +: ROC_NUM_IN];
  assign cfg.en = ctrl_q[ROC_CTRL_EN_LSB +: ROC_NUM_IN];
  assign cfg.latch = ctrl_q[ROC_CTRL_LATCH];
  assign cfg.mode = roc_mode_e'(ctrl_q[ROC_CTRL_MODE]);
  assign cfg.ack_sel = ctrl_q[ROC_CTRL_ACK_LSB +: ROC_SEL_W];
  assign cfg.hold = hold_q;
  assign cfg.off_dly = off_q;
  wire [ROC_NUM_IN*ROC_SEL_W-1:0] sel = {sel_hi_q[4:0], sel_lo_q[29:0]};

  roc_tick #(.DIV(TICK_CYC)) u_tick (
    .pclk(pclk),
    .presetn(presetn),
    .tick(tick)
  );

  roc_core u_core (
    .pclk(pclk),
    .presetn(presetn),
    .tick(tick),
    .src(sync2_q),
    .sel(sel),
    .cfg(cfg),
    .stat(stat),
    .relay_drive(relay_drive)
  );
endmodule
`default_nettype wire

// File: verilog/roc_pkg.sv
// Purpose: Shared constants, types and register map for relay output conditioning
// Assumes: 10 MHz pclk, APB register access, 32-bit data
// Notes: Timer settings count 10 ms ticks
package roc_pkg;
  // ==========================================
  // Sizes
  localparam int ROC_NUM_IN = 7;
  localparam int ROC_SEL_W = 5;
  localparam int ROC_NUM_SRC = 32;
  // ==========================================
  // Timing: settings in units of 10 ms, max 300.00 s
  localparam int ROC_TICK_US = 10000;
  localparam int ROC_CLK_MHZ = 10;
  localparam int ROC_TICK_CYC = ROC_TICK_US * ROC_CLK_MHZ;
  localparam logic [14:0] ROC_TIME_MAX = 15'h7530;
  localparam logic [14:0] ROC_TIME_RST = 15'h0000;
  // ==========================================
  // Register byte offsets
  localparam logic [7:0] ROC_OFS_CTRL = 8'h00;
  localparam logic [7:0] ROC_OFS_SEL_LO = 8'h04;
  localparam logic [7:0] ROC_OFS_SEL_HI = 8'h08;
  localparam logic [7:0] ROC_OFS_HOLD = 8'h0c;
  localparam logic [7:0] ROC_OFS_OFFDLY = 8'h10;
  localparam logic [7:0] ROC_OFS_STAT = 8'h14;
  // ==========================================
  // Control field positions
  localparam int ROC_CTRL_INV_LSB = 0;
  localparam int ROC_CTRL_EN_LSB = 8;
  localparam int ROC_CTRL_LATCH = 16;
  localparam int ROC_CTRL_MODE = 17;
  localparam int ROC_CTRL_ACK_LSB = 24;
  localparam logic [31:0] ROC_CTRL_RST = 32'h0000_0000;
  localparam logic [31:0] ROC_SEL_RST = 32'h0000_0000;

  // Operating mode of relay drive
  typedef enum logic {ROC_WORKING, ROC_CLOSED} roc_mode_e;

  // Configuration carried to the relay core
  typedef struct packed {
    logic [ROC_NUM_IN-1:0] inv;
    logic [ROC_NUM_IN-1:0] en;
    logic latch;
    roc_mode_e mode;
    logic [ROC_SEL_W-1:0] ack_sel;
    logic [14:0] hold;
    logic [14:0] off_dly;
  } roc_cfg_s;

  // Status carried back
  typedef struct packed {
    logic cmd;
    logic latched;
    logic state;
    logic holding;
    logic delaying;
  } roc_stat_s;
endpackage

// File: verilog/roc_tick.sv
// Purpose: 10 ms enable pulse divider
// Assumes: single clock pclk
// Notes: pulse is one cycle wide
`timescale 1ns/1ns
`default_nettype none
module roc_tick #(
  parameter int DIV = roc_pkg::ROC_TICK_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  output logic tick
);
  import roc_pkg::*;
  // ==========================================
  // Divider
  if (DIV < 1) $error("DIV must be positive");
  logic [31:0] cnt_q;
  // Wrap at DIV-1
  wire last = (cnt_q == 32'(DIV - 1));
  // Counter and pulse
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt_q <= 32'h0;
      tick <= 1'b0;
    end
    else
    begin
      cnt_q <= last ? 32'h0 : cnt_q + 32'h1;
      tick <= last;
    end
  end
endmodule
`default_nettype wire

// File: verilog/roc_core.sv
// Purpose: Relay command shaping: combine, latch, off delay, hold, mode
// Assumes: signals already synchronised, tick is 10 ms enable
// Notes: relay_drive is registered
`timescale 1ns/1ns
`default_nettype none
module roc_core (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic tick,
  input wire logic [roc_pkg::ROC_NUM_SRC-1:0] src,
  input wire logic [roc_pkg::ROC_NUM_IN*roc_pkg::ROC_SEL_W-1:0] sel,
  input wire roc_pkg::roc_cfg_s cfg,
  output roc_pkg::roc_stat_s stat,
  output logic relay_drive
);
  import roc_pkg::*;
  // ==========================================
  // Input combination
  logic [ROC_NUM_IN-1:0] term;
  // Pick, invert and gate each input
  always_comb
  begin
    for (int i = 0; i < ROC_NUM_IN; i++)
    begin
      term[i] = cfg.en[i] & (src[sel[i*ROC_SEL_W +: ROC_SEL_W]] ^ cfg.inv[i]);
    end
  end
  wire cmd = |term;
  wire ack_raw = src[cfg.ack_sel];
  wire ack = cfg.latch & ack_raw;

  // ==========================================
  // Latch
  logic latched_q;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      latched_q <= 1'b0;
    else if (cfg.latch && cmd)
      latched_q <= 1'b1;
    else if (ack || !cfg.latch)
      latched_q <= 1'b0;
  end
  wire want = cmd | latched_q;

  // ==========================================
  // Off delay and hold timers
  logic [14:0] off_q;
  logic [14:0] hold_q;
  logic state_q;
  logic delaying_q;
  wire hold_busy = (hold_q != 15'h0);
  // Off request matures when delay elapsed
  wire off_due = (cfg.off_dly == 15'h0) || (delaying_q && off_q == 15'h0);
  wire go_on = !state_q && want && !hold_busy;
  wire go_off = state_q && !want && off_due && !hold_busy;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      off_q <= ROC_TIME_RST;
      delaying_q <= 1'b0;
    end
    else if (state_q && !want)
    begin
      if (!delaying_q)
      begin
        delaying_q <= 1'b1;
        off_q <= cfg.off_dly;
      end
      else if (tick && off_q != 15'h0)
        off_q <= off_q - 15'h1;
    end
    else
    begin
      delaying_q <= 1'b0;
      off_q <= ROC_TIME_RST;
    end
  end
  // Relay state and hold timer
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state_q <= 1'b0;
      hold_q <= ROC_TIME_RST;
    end
    else if (go_on || go_off)
    begin
      state_q <= go_on;
      hold_q <= cfg.hold;
    end
    else if (tick && hold_busy)
      hold_q <= hold_q - 15'h1;
  end

  // ==========================================
  // Output stage
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      relay_drive <= 1'b0;
      stat <= '0;
    end
    else
    begin
      relay_drive <= (cfg.mode == ROC_CLOSED) ? !state_q : state_q;
      stat <= '{cmd: cmd, latched: latched_q, state: state_q,
                holding: hold_busy, delaying: delaying_q};
    end
  end
endmodule
`default_nettype wire

// File: bench/roc_monitor.sv
// Purpose: Port-level timing checks for relay output conditioning
// Assumes: registers written as whole words
// Notes: config is shadowed from APB writes
`timescale 1ns/1ns
`default_nettype none
module roc_monitor #(
  parameter int TICK_CYC = roc_pkg::ROC_TICK_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic [roc_pkg::ROC_NUM_SRC-1:0] sig_in,
  input wire logic relay_drive
);
  import roc_pkg::*;
  // ==========================================
  // Shadow config and age counters
  logic [31:0] ctl_q, sel_q, sig_q;
  logic [14:0] hold_q, off_q;
  logic [4:0] sh_q;
  logic drv_q;
  logic [6:0] term;
  int quiet_q, stab_q, chg_q, low_q, ackl_q, lim;
  wire wr_en = psel && penable && pready && pwrite;
  // Source indices of all seven inputs
  wire [34:0] selv = {sh_q, sel_q[29:0]};
  // Per-input term: enable, invert, source
  always_comb
    for (int i = 0; i < 7; i++)
      term[i] = ctl_q[8+i] & (ctl_q[i] ^ sig_in[selv[5*i+:5]]);
  wire want = |term;
  wire ack = sig_in[ctl_q[28:24]];
  wire latch = ctl_q[16];
  wire pick = relay_drive ^ ctl_q[17];
  assign lim = (hold_q + off_q + 2) * TICK_CYC + 8;
  // Track writes and ages
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      {ctl_q, sel_q, sig_q, hold_q, off_q, sh_q, drv_q} <= '0;
      {quiet_q, stab_q, chg_q, low_q, ackl_q} <= '0;
    end
    else
    begin
      if (wr_en && paddr == ROC_OFS_CTRL) ctl_q <= pwdata;
      if (wr_en && paddr == ROC_OFS_SEL_LO) sel_q <= pwdata;
      if (wr_en && paddr == ROC_OFS_SEL_HI) sh_q <= pwdata[4:0];
      if (wr_en && paddr == ROC_OFS_HOLD) hold_q <= pwdata[14:0];
      if (wr_en && paddr == ROC_OFS_OFFDLY) off_q <= pwdata[14:0];
      sig_q <= sig_in;
      drv_q <= relay_drive;
      quiet_q <= wr_en ? 0 : quiet_q + 1;
      stab_q <= (wr_en || sig_in != sig_q) ? 0 : stab_q + 1;
      chg_q <= (relay_drive != drv_q) ? 0 : chg_q + 1;
      low_q <= want ? 0 : low_q + 1;
      ackl_q <= ack ? 0 : ackl_q + 1;
    end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ==========================================
  // Properties
  sequence s_free;
    stab_q == lim && !latch;
  endsequence
  sequence s_acked;
    stab_q == lim && latch && ack;
  endsequence
  property p_settle;
    s_free |-> relay_drive == (ctl_q[17] ^ want);
  endproperty
  property p_ack;
    s_acked |-> pick == want;
  endproperty
  property p_hold;
    relay_drive != drv_q && quiet_q >= lim |-> chg_q + TICK_CYC >= hold_q * TICK_CYC;
  endproperty
  property p_latch;
    latch && quiet_q >= lim && ackl_q >= lim && $past(pick) |-> pick;
  endproperty
  property p_offdly;
    $fell(pick) && quiet_q >= lim |-> low_q + TICK_CYC >= off_q * TICK_CYC;
  endproperty
  property p_rest;
    $rose(presetn) |-> !relay_drive;
  endproperty
  a_settle: assert property (p_settle) else $error("drive not settled");
  a_ack: assert property (p_ack) else $error("ack did not release");
  a_hold: assert property (p_hold) else $error("state not held");
  a_latch: assert property (p_latch) else $error("latch lost");
  a_offdly: assert property (p_offdly) else $error("off too early");
  a_rest: assert property (p_rest) else $error("rest drive on");
endmodule
bind roc_top roc_monitor #(.TICK_CYC(TICK_CYC)) u_roc_monitor (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .pready(pready), .sig_in(sig_in), .relay_drive(relay_drive));
`default_nettype wire

// File: bench/testbench.sv
// Purpose: Scenario bench for relay output conditioning
// Assumes: tick shortened to 10 cycles
// Notes: registers reached over APB
`timescale 1ns/1ns
`default_nettype none
module testbench;
  import roc_pkg::*;
  // ==========================================
  // Signals
  localparam int TC = 10;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] sig_in = 32'h0;
  logic [31:0] prdata, rd;
  logic pready, pslverr, err, relay_drive;
  int n_mismatch = 0;
  int cmp_count = 0;
`define CHK(a, b, m) begin cmp_count++; if ((a) !== (b)) begin n_mismatch++; $display("wrong value at %0t: %s", $time, m); end end
  always #50 pclk = ~pclk;
  roc_top #(.TICK_CYC(TC)) u_roc_top (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hf),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .sig_in(sig_in),
    .relay_drive(relay_drive));
  // ==========================================
  // Helpers
  task automatic cy(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // Wait for the answer; only the watchdog ends a hang
    while (pready !== 1'b1)
      @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Bounded wait for a drive level
  task automatic wt(input logic e, input int n);
    int k;
    k = 0;
    while (relay_drive !== e && k < n)
    begin
      @(posedge pclk);
      k++;
    end
  endtask
  task automatic sg(input int b, input logic v);
    @(posedge pclk);
    sig_in[b] <= v;
  endtask
  // ==========================================
  // Scenarios
  task automatic t_regs;
    apb(1'b0, ROC_OFS_CTRL, 32'h0);
    `CHK(rd, ROC_CTRL_RST, "ctrl reset")
    apb(1'b0, ROC_OFS_HOLD, 32'h0);
    `CHK(rd, 32'h0, "hold reset")
    apb(1'b0, 8'h40, 32'h0);
    `CHK(err, 1'b1, "unmapped error")
    `CHK(relay_drive, 1'b0, "rest drive")
    $display("done t_regs");
  endtask
  task automatic t_inv;
    apb(1'b1, ROC_OFS_SEL_LO, 32'h3);
    apb(1'b1, ROC_OFS_SEL_HI, 32'h7);
    apb(1'b1, ROC_OFS_CTRL, 32'h101);
    wt(1'b1, 20);
    `CHK(relay_drive, 1'b1, "inverted low")
    sg(3, 1'b1);
    wt(1'b0, 20);
    `CHK(relay_drive, 1'b0, "inverted high")
    apb(1'b1, ROC_OFS_CTRL, 32'h4000);
    sg(7, 1'b1);
    wt(1'b1, 20);
    `CHK(relay_drive, 1'b1, "input six")
    sg(7, 1'b0);
    sg(3, 1'b0);
    cy(30);
    `CHK(relay_drive, 1'b0, "input six off")
    $display("done t_inv");
  endtask
  task automatic t_hold;
    apb(1'b1, ROC_OFS_CTRL, 32'h100);
    apb(1'b1, ROC_OFS_HOLD, 32'h3);
    cy(60);
    sg(3, 1'b1);
    wt(1'b1, 20);
    sg(3, 1'b0);
    cy(15);
    `CHK(relay_drive, 1'b1, "held on")
    wt(1'b0, 60);
    `CHK(relay_drive, 1'b0, "released")
    apb(1'b1, ROC_OFS_HOLD, 32'h0);
    $display("done t_hold");
  endtask
  task automatic t_off;
    apb(1'b1, ROC_OFS_OFFDLY, 32'h2);
    cy(50);
    sg(3, 1'b1);
    wt(1'b1, 20);
    sg(3, 1'b0);
    cy(12);
    `CHK(relay_drive, 1'b1, "off delayed")
    wt(1'b0, 50);
    `CHK(relay_drive, 1'b0, "off")
    apb(1'b1, ROC_OFS_OFFDLY, 32'h0);
    apb(1'b1, ROC_OFS_CTRL, 32'h2_0100);
    cy(30);
    `CHK(relay_drive, 1'b1, "closed rest")
    sg(3, 1'b1);
    wt(1'b0, 20);
    `CHK(relay_drive, 1'b0, "closed active")
    sg(3, 1'b0);
    $display("done t_off");
  endtask
  task automatic t_latch;
    apb(1'b1, ROC_OFS_CTRL, 32'h0501_0100);
    sg(3, 1'b1);
    wt(1'b1, 20);
    sg(3, 1'b0);
    cy(30);
    `CHK(relay_drive, 1'b1, "latched")
    apb(1'b0, ROC_OFS_STAT, 32'h0);
    `CHK(rd, 32'h0000_000c, "latch status")
    sg(5, 1'b1);
    wt(1'b0, 20);
    cy(30);
    `CHK(relay_drive, 1'b0, "acknowledged")
    sg(5, 1'b0);
    apb(1'b1, ROC_OFS_CTRL, 32'h0500_0100);
    sg(3, 1'b1);
    sg(5, 1'b1);
    cy(30);
    `CHK(relay_drive, 1'b1, "ack ignored")
    $display("done t_latch");
  endtask
  task automatic final_report;
    $display("comparisons %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // Main sequence
  initial
  begin
    cy(5);
    presetn <= 1'b1;
    t_regs;
    t_inv;
    t_hold;
    t_off;
    t_latch;
    final_report;
  end
  // Watchdog
  initial
  begin
    #2000000;
    n_mismatch++;
    final_report;
  end
endmodule
`default_nettype wire
